// ===== logic/fpc_map.svh
// Purpose: Register offsets, field positions, codes and timing for the flash program controller
// Assumes: SFR bus with 8-bit address and data
// Notes:   Definitions only
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH

`define FPC_ADDR_SECT_HIGH 8'hfa
`define FPC_ADDR_SECT_MID 8'hfb
`define FPC_ADDR_SECT_LOW 8'hfc
`define FPC_ADDR_KEY 8'hfd
`define FPC_ADDR_CMD 8'hfe
`define FPC_RESET_BYTE 8'h00
`define FPC_KEY_VALID 8'ha5
`define FPC_CMD_BUSY_BIT 7
`define FPC_CMD_CODE_W 3
`define FPC_HIGH_W 4
`define FPC_PROT_START 15'h0100
`define FPC_PROT_END_00 15'h0fff
`define FPC_PROT_END_01 15'h07ff
`define FPC_PROT_END_10 15'h03ff
`define FPC_PROT_END_11 15'h01ff
`define FPC_PAGE_BYTES 64
`define FPC_OFS_W 6
`define FPC_ERASED_BYTE 8'h00
`define FPC_ERASE_NS 2500
`define FPC_WRITE_NS 2500
`define FPC_LOCK_NS 2500
`define FPC_CLK_NS 4

`endif

// ===== logic/fpc_pkg.sv
// Purpose: Types shared by the flash program controller
// Assumes: Included map header gives code widths
// Notes:   Types only
`default_nettype none
`include "fpc_map.svh"
package fpc_pkg;
    typedef enum logic [2:0] {
        FPC_CMD_NONE = 3'h0,
        FPC_CMD_BUF_CLEAR = 3'h1,
        FPC_CMD_ERASE = 3'h2,
        FPC_CMD_WRITE = 3'h3,
        FPC_CMD_LOCK = 3'h4
    } fpc_cmd_t;

    // Special function register access from the CPU or debugger
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fpc_sfr_req_t;

    // Page buffer load through external-data write
    typedef struct packed {
        logic wr;
        logic [5:0] ofs;
        logic [7:0] data;
    } fpc_buf_req_t;
endpackage
`default_nettype wire

// ===== logic/fpc_ctrl.sv
// Purpose: Flash program controller: sector erase, sector write, hard lock, page buffer
// Assumes: Requests synchronous to core_clk_i; flash array modelled by an internal memory
// Notes:   CPU is held by stall_o while an array operation runs
`timescale 1ns/1ns
`default_nettype none
`include "fpc_map.svh"

// What this block does
// - Holds 32 KB program flash, readable by code reads, programmable only in programming mode.
// - Flash control registers live in SFR space, accessed only in programming mode.
// - Sector address is 4-bit high, 8-bit middle, 8-bit low read/write registers.
// - Erase, write and hard lock start only with key 10100101 loaded.
// - After each operation the key and the mode code clear to zero.
// - Code 0x02 with valid key erases the loaded bytes of the addressed sector.
// - Code 0x03 with valid key programs page buffer into addressed sector.
// - Code 0x04 with valid key starts the hard-lock operation.
// - Any other mode code starts no flash operation.
// - Protection enable 0 refuses erase and program inside protection area.
// - Size select picks area 0100H to 0FFFH, 07FFH, 03FFH or 01FFH.
// - Sector and page buffer are 64 bytes; buffer loaded byte by byte.
// - Flash bytes are returned to code reads addressed through the data pointer.
// - Serial in-system programming reaches these registers over the debugger link.
module fpc_ctrl
    import fpc_pkg::*;
#(
    parameter int unsigned FLASH_BYTES = 32768,
    parameter int unsigned ERASE_CYCLES = (`FPC_ERASE_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS,
    parameter int unsigned WRITE_CYCLES = (`FPC_WRITE_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS,
    parameter int unsigned LOCK_CYCLES = (`FPC_LOCK_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic prog_mode_i,
    input wire fpc_sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    input wire fpc_buf_req_t buf_req_i,
    input wire logic code_rd_i,
    input wire logic [14:0] code_addr_i,
    output logic [7:0] code_rdata_o,
    input wire logic protect_region_enable_n_i,
    input wire logic protect_size_sel_hi_i,
    input wire logic protect_size_sel_lo_i,
    output logic stall_o,
    output logic hard_lock_o,
    output logic refused_o
);
    typedef enum logic [1:0] {FPC_IDLE, FPC_ERASE, FPC_WRITE, FPC_LOCK} fpc_state_t;

    localparam int unsigned CNT_W = 16;

    // Block overview
    // - SFR port: five byte registers, open only in programming mode
    // - CPU and serial debugger share one request port
    // - Page buffer: 64 bytes, loaded one byte per request
    // - Loaded marks: one bit per buffer byte, cleared with the buffer
    // - Sequencer: wait count, then one byte step per cycle
    // - Array: behavioural memory standing in for the flash macro
    // - Stall: held high for the whole array operation
    // - Protection: checked once, on the sector base, at start
    // - Hard lock: only raises a sticky output
    // - Erased bytes read back as zero

    // Memory notes
    // - Flash array contents carry no reset
    // - Unwritten bytes read as unknown in simulation
    // - Page buffer contents carry no reset either
    // - Only the loaded marks are reset
    // - Code reads are not blocked while busy; CPU is stalled instead

    // Flash array and page buffer
    logic [7:0] flash_mem [FLASH_BYTES];
    logic [7:0] page_buf [`FPC_PAGE_BYTES];
    logic [`FPC_PAGE_BYTES-1:0] page_loaded;

    // Registers
    logic [`FPC_HIGH_W-1:0] sector_addr_high;
    logic [7:0] sector_addr_middle;
    logic [7:0] sector_addr_low;
    logic [7:0] unlock_key;
    logic [`FPC_CMD_CODE_W-1:0] flash_command;
    fpc_state_t state;
    logic [CNT_W-1:0] op_cnt;
    logic [`FPC_OFS_W-1:0] op_ofs;

    // Register hazards
    // - Key and command writes while busy are dropped
    // - Key is single use: any command write consumes it
    // - Buffer loads while busy are dropped
    // - Software still owes three idle cycles after a command
    // - Read and write in one request: write takes effect, read sees old value

    // Decodes; the debugger link reaches the same port
    wire logic sfr_ok = prog_mode_i;
    wire logic wr_high = sfr_ok & sfr_req_i.wr & (sfr_req_i.addr == `FPC_ADDR_SECT_HIGH);
    wire logic wr_mid = sfr_ok & sfr_req_i.wr & (sfr_req_i.addr == `FPC_ADDR_SECT_MID);
    wire logic wr_low = sfr_ok & sfr_req_i.wr & (sfr_req_i.addr == `FPC_ADDR_SECT_LOW);
    wire logic wr_key = sfr_ok & sfr_req_i.wr & (sfr_req_i.addr == `FPC_ADDR_KEY);
    wire logic wr_cmd = sfr_ok & sfr_req_i.wr & (sfr_req_i.addr == `FPC_ADDR_CMD);
    wire logic busy = (state != FPC_IDLE);
    wire logic key_ok = (unlock_key == `FPC_KEY_VALID);
    wire fpc_cmd_t new_cmd = fpc_cmd_t'(sfr_req_i.wdata[`FPC_CMD_CODE_W-1:0]);

    // Sector address notes
    // - Only bits 14 down to 6 pick the sector
    // - All four bits of the high register are kept but unused
    // - Low 6 bits are ignored; the walk supplies the byte offset
    // - Address may change while busy without harm to the running walk
    //   only if software keeps to the ordered sequence

    // Sector base from the three address registers, low 6 bits select the byte
    wire logic [19:0] sect_full = {sector_addr_high, sector_addr_middle, sector_addr_low};
    wire logic [14:0] sect_base = {sect_full[14:`FPC_OFS_W], {`FPC_OFS_W{1'b0}}};
    wire logic [14:0] op_addr = {sect_base[14:`FPC_OFS_W], op_ofs};

    // Protection notes
    // - Option pins are levels, read at command time
    // - Area always starts at the same base
    // - Only the sector base is compared, not each byte
    // - A refused command still consumes key and command
    // - Hard lock is never refused by protection

    // Protection area end selected by size option
    wire logic [1:0] size_sel = {protect_size_sel_hi_i, protect_size_sel_lo_i};
    wire logic [14:0] prot_end = (size_sel == 2'h0) ? `FPC_PROT_END_00 :
                                 (size_sel == 2'h1) ? `FPC_PROT_END_01 :
                                 (size_sel == 2'h2) ? `FPC_PROT_END_10 : `FPC_PROT_END_11;
    wire logic in_prot = (sect_base >= `FPC_PROT_START) && (sect_base <= prot_end);
    wire logic prot_block = ~protect_region_enable_n_i & in_prot;

    // Start rules
    // - Buffer clear needs no key and never stalls
    // - Erase and write need the key and an open sector
    // - Hard lock needs the key only
    // - Undefined codes only consume the key
    // - Nothing starts while an operation runs

    // Command start conditions
    wire logic start_clear = wr_cmd & ~busy & (new_cmd == FPC_CMD_BUF_CLEAR);
    wire logic start_erase = wr_cmd & ~busy & key_ok & (new_cmd == FPC_CMD_ERASE) & ~prot_block;
    wire logic start_write = wr_cmd & ~busy & key_ok & (new_cmd == FPC_CMD_WRITE) & ~prot_block;
    wire logic start_lock = wr_cmd & ~busy & key_ok & (new_cmd == FPC_CMD_LOCK);
    wire logic start_any = start_erase | start_write | start_lock;
    wire logic is_array_cmd = (new_cmd == FPC_CMD_ERASE) | (new_cmd == FPC_CMD_WRITE);
    wire logic refuse_now = wr_cmd & ~busy & key_ok & is_array_cmd & prot_block;
    wire logic op_last = (op_cnt == '0);
    wire logic one_shot_done = wr_cmd & ~busy & ~start_any;
    wire logic done = busy & op_last & (op_ofs == `FPC_OFS_W'(`FPC_PAGE_BYTES - 1));
    wire logic lock_done = (state == FPC_LOCK) & op_last;

    // Read side
    // - Busy bit sits in the top position, read only
    // - Middle bits of the command register read zero
    // - Read data is registered and held until the next read

    // Read data mux; unmapped or outside programming mode reads zero
    wire logic [7:0] rd_mux =
        ~sfr_ok ? `FPC_RESET_BYTE :
        (sfr_req_i.addr == `FPC_ADDR_SECT_HIGH) ? {4'h0, sector_addr_high} :
        (sfr_req_i.addr == `FPC_ADDR_SECT_MID) ? sector_addr_middle :
        (sfr_req_i.addr == `FPC_ADDR_SECT_LOW) ? sector_addr_low :
        (sfr_req_i.addr == `FPC_ADDR_KEY) ? unlock_key :
        (sfr_req_i.addr == `FPC_ADDR_CMD) ? {busy, 4'h0, flash_command} : `FPC_RESET_BYTE;

    // Address registers
    // Plain read/write bytes, no side effects
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sector_addr_high <= '0;
            sector_addr_middle <= `FPC_RESET_BYTE;
            sector_addr_low <= `FPC_RESET_BYTE;
        end else begin
            if (wr_high) begin
                sector_addr_high <= sfr_req_i.wdata[`FPC_HIGH_W-1:0];
            end
            if (wr_mid) begin
                sector_addr_middle <= sfr_req_i.wdata;
            end
            if (wr_low) begin
                sector_addr_low <= sfr_req_i.wdata;
            end
        end
    end

    // Key and command notes
    // - Clear wins over a key write in the same cycle
    // - Command register holds the running code while busy
    // - Both read zero once the operation ends

    // Key and command clear after each operation
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            unlock_key <= `FPC_RESET_BYTE;
            flash_command <= '0;
        end else if (one_shot_done || done || lock_done) begin
            unlock_key <= `FPC_RESET_BYTE;
            flash_command <= '0;
        end else if (start_any) begin
            flash_command <= new_cmd;
        end else if (wr_key && !busy) begin
            unlock_key <= sfr_req_i.wdata;
        end
    end

    // Sequencer timing
    // - Start edge loads the wait count
    // - Count runs down to zero
    // - Then one byte step per cycle, offsets 0 to 63
    // - Last step returns to idle
    // - Hard lock has the wait only, no byte walk
    // - Erase or write lasts wait cycles plus 64 steps
    // - Offset is parked at zero while idle

    // Operation sequencer
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= FPC_IDLE;
            op_cnt <= '0;
            op_ofs <= '0;
        end else begin
            unique case (state)
                FPC_IDLE: begin
                    op_ofs <= '0;
                    if (start_erase) begin
                        state <= FPC_ERASE;
                        op_cnt <= CNT_W'(ERASE_CYCLES - 1);
                    end else if (start_write) begin
                        state <= FPC_WRITE;
                        op_cnt <= CNT_W'(WRITE_CYCLES - 1);
                    end else if (start_lock) begin
                        state <= FPC_LOCK;
                        op_cnt <= CNT_W'(LOCK_CYCLES - 1);
                    end
                end
                FPC_ERASE, FPC_WRITE: begin
                    if (!op_last) begin
                        op_cnt <= op_cnt - 1'b1;
                    end else if (done) begin
                        state <= FPC_IDLE;
                    end else begin
                        op_ofs <= op_ofs + 1'b1; // Walk all 64 bytes
                    end
                end
                FPC_LOCK: begin
                    if (!op_last) begin
                        op_cnt <= op_cnt - 1'b1;
                    end else begin
                        state <= FPC_IDLE;
                    end
                end
            endcase
        end
    end

    // Page buffer notes
    // - Clear wins over a load in the same cycle
    // - A byte loaded twice keeps the later value
    // - Marks decide which sector bytes an operation touches

    // Page buffer with loaded-byte marks
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            page_loaded <= '0;
        end else if (start_clear) begin
            page_loaded <= '0;
        end else if (buf_req_i.wr && !busy) begin
            page_loaded[buf_req_i.ofs] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < `FPC_PAGE_BYTES; i++) begin
            if (start_clear) page_buf[i] <= `FPC_RESET_BYTE;
        end
        if (!start_clear && buf_req_i.wr && !busy) page_buf[buf_req_i.ofs] <= buf_req_i.data;
    end

    // Array notes
    // - One byte per step, at the offset under the walk
    // - Erase writes the erased value, write copies the buffer
    // - Unloaded bytes keep their old contents
    // - Hard lock never touches the array

    // Array update: only loaded bytes change the sector
    always_ff @(posedge core_clk_i) begin
        if (busy && op_last && (state != FPC_LOCK) && page_loaded[op_ofs]) begin
            if (state == FPC_ERASE) flash_mem[op_addr] <= `FPC_ERASED_BYTE;
            else flash_mem[op_addr] <= page_buf[op_ofs];
        end
    end

    // Output notes
    // - All outputs are registered
    // - Stall rises the cycle after start and falls after the last step
    // - Refusal is a one-cycle pulse
    // - Hard lock stays set until reset
    // - Code read data holds until the next code read

    // Outputs
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o <= `FPC_RESET_BYTE;
            code_rdata_o <= `FPC_RESET_BYTE;
            stall_o <= 1'b0;
            hard_lock_o <= 1'b0;
            refused_o <= 1'b0;
        end else begin
            sfr_rdata_o <= sfr_req_i.rd ? rd_mux : sfr_rdata_o;
            if (code_rd_i) code_rdata_o <= flash_mem[code_addr_i];
            stall_o <= start_any | (busy & ~done & ~lock_done);
            if (lock_done) hard_lock_o <= 1'b1;
            refused_o <= refuse_now;
        end
    end
endmodule // fpc_ctrl
`default_nettype wire

// ===== testbench/fpc_ctrl_sva.sv
// Purpose: Port checker for fpc_ctrl
// Assumes: Key validity tracked from SFR writes
// Notes: Bound to the design at the foot
`timescale 1ns/1ns
`default_nettype none
`include "fpc_map.svh"
module fpc_ctrl_sva
    import fpc_pkg::*;
#(parameter int unsigned FLASH_BYTES = 32768, ERASE_CYCLES = 625, WRITE_CYCLES = 625, LOCK_CYCLES = 625) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic prog_mode_i,
    input wire fpc_sfr_req_t sfr_req_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic stall_o,
    input wire logic hard_lock_o,
    input wire logic refused_o
);
    localparam int MAXS = ERASE_CYCLES + WRITE_CYCLES + LOCK_CYCLES + 70;
    logic key_ok;
    int stall_n;
    wire cmd_wr = sfr_req_i.wr && prog_mode_i && sfr_req_i.addr == `FPC_ADDR_CMD && !stall_o;
    wire rd_cmd = sfr_req_i.rd && prog_mode_i && sfr_req_i.addr == `FPC_ADDR_CMD;
    wire [2:0] code = sfr_req_i.wdata[2:0];
    // Key seen valid, and length of the current stall
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) key_ok <= 1'b0;
        else if (cmd_wr || stall_o) key_ok <= 1'b0;
        else if (sfr_req_i.wr && prog_mode_i && sfr_req_i.addr == `FPC_ADDR_KEY) key_ok <= sfr_req_i.wdata == 8'ha5;
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) stall_n <= 0;
        else stall_n <= stall_o ? stall_n + 1 : 0;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_lock_go; cmd_wr && key_ok && code == 3'h4 |=> stall_o; endproperty
    a_lock_go: assert property (p_lock_go) else $error("lock did not start");
    property p_no_key; cmd_wr && !key_ok |=> !stall_o; endproperty
    a_no_key: assert property (p_no_key) else $error("started without key");
    property p_bad_code; cmd_wr && (code == 3'h0 || code > 3'h4) |=> !stall_o; endproperty
    a_bad_code: assert property (p_bad_code) else $error("undefined code started");
    property p_clear_fast; cmd_wr && code == 3'h1 |=> !stall_o; endproperty
    a_clear_fast: assert property (p_clear_fast) else $error("buffer clear stalled");
    property p_idle_busy; rd_cmd && !stall_o |=> !sfr_rdata_o[7]; endproperty
    a_idle_busy: assert property (p_idle_busy) else $error("busy while idle");
    property p_closed; sfr_req_i.rd && !prog_mode_i |=> sfr_rdata_o == 8'h00; endproperty
    a_closed: assert property (p_closed) else $error("read outside programming mode");
    property p_refuse; refused_o |-> !stall_o ##1 !refused_o; endproperty
    a_refuse: assert property (p_refuse) else $error("refusal not a lone pulse");
    property p_stall_len; stall_n <= MAXS; endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall too long");
    property p_lock_end; $rose(hard_lock_o) |-> $past(stall_o); endproperty
    a_lock_end: assert property (p_lock_end) else $error("lock set outside operation");
endmodule // fpc_ctrl_sva
bind fpc_ctrl fpc_ctrl_sva #(.FLASH_BYTES(FLASH_BYTES), .ERASE_CYCLES(ERASE_CYCLES),
    .WRITE_CYCLES(WRITE_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_sva (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .prog_mode_i(prog_mode_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
    .stall_o(stall_o), .hard_lock_o(hard_lock_o), .refused_o(refused_o));
`default_nettype wire

// ===== testbench/flash_program_controller_tb.sv
// Purpose: Self-checking bench for fpc_ctrl
// Assumes: Short operation counts
// Notes: Read results checked against a queue
`timescale 1ns/1ns
`default_nettype none
`include "fpc_map.svh"
module flash_program_controller_tb
    import fpc_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, pmode = 1'b1, crd = 1'b0, pen_n = 1'b1, psh = 1'b0, psl = 1'b0;
    logic [14:0] caddr = '0;
    fpc_sfr_req_t sreq = '0;
    fpc_buf_req_t breq = '0;
    logic [7:0] srd, crdat, v;
    logic stall, hlock, refused, sp = 1'b0, cp = 1'b0;
    logic [7:0] expq[$];
    logic [31:0] seed = 32'hcd14;
    int errors = 0, checks_done = 0, ref_cnt = 0;
    fpc_ctrl #(.ERASE_CYCLES(4), .WRITE_CYCLES(4), .LOCK_CYCLES(8)) DUT (.core_clk_i(clk), .rst_b_i(rst_b),
        .prog_mode_i(pmode), .sfr_req_i(sreq), .sfr_rdata_o(srd), .buf_req_i(breq), .code_rd_i(crd),
        .code_addr_i(caddr), .code_rdata_o(crdat), .protect_region_enable_n_i(pen_n),
        .protect_size_sel_hi_i(psh), .protect_size_sel_lo_i(psl), .stall_o(stall), .hard_lock_o(hlock),
        .refused_o(refused));
    initial begin
        forever #2 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        sreq <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        sreq <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        sfr(1'b0, a, 8'h00);
    endtask
    task automatic cread(input logic [14:0] a, input logic [7:0] e);
        expq.push_back(e);
        crd <= 1'b1;
        caddr <= a;
        @(posedge clk);
        crd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic bput(input logic [5:0] o, input logic [7:0] d);
        breq <= '{wr: 1'b1, ofs: o, data: d};
        @(posedge clk);
        breq <= '0;
        @(posedge clk);
    endtask
    task automatic sect(input logic [15:0] a);
        sfr(1'b1, `FPC_ADDR_SECT_MID, a[15:8]);
        sfr(1'b1, `FPC_ADDR_SECT_LOW, a[7:0]);
    endtask
    task automatic op(input logic [7:0] k, input logic [2:0] c, input logic post);
        sfr(1'b1, `FPC_ADDR_KEY, k);
        sfr(1'b1, `FPC_ADDR_CMD, {5'h0, c});
        if (c == 3'h3 && k == 8'ha5) rd(`FPC_ADDR_CMD, 8'h83);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 400 && stall; i++) @(posedge clk);
        if (post) rd(`FPC_ADDR_CMD, 8'h00);
        if (post) rd(`FPC_ADDR_KEY, 8'h00);
    endtask
    task automatic prot(input logic [15:0] a, input logic e);
        int n;
        n = ref_cnt;
        sect(a);
        op(8'ha5, 3'h2, !e);
        check(8'(ref_cnt - n), {7'h0, e});
    endtask
    // Read results come off the queue; refusals are counted
    always @(posedge clk) begin
        if (sp) check(srd, expq.pop_front());
        if (cp) check(crdat, expq.pop_front());
        sp <= sreq.rd;
        cp <= crd;
        if (refused) ref_cnt <= ref_cnt + 1;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int a = 8'hfa; a <= 8'hfe; a++) rd(a[7:0], 8'h00);
        sfr(1'b1, `FPC_ADDR_SECT_HIGH, 8'hff);
        rd(`FPC_ADDR_SECT_HIGH, 8'h0f);
        v = rnd();
        sfr(1'b1, `FPC_ADDR_SECT_LOW, v);
        pmode <= 1'b0;
        sfr(1'b1, `FPC_ADDR_SECT_LOW, ~v);
        rd(`FPC_ADDR_SECT_LOW, 8'h00);
        pmode <= 1'b1;
        rd(`FPC_ADDR_SECT_LOW, v);
        sfr(1'b1, `FPC_ADDR_SECT_HIGH, 8'h00);
        sfr(1'b1, `FPC_ADDR_CMD, 8'h01);
        for (int i = 0; i < 64; i++) bput(i[5:0], i[7:0]);
        sect(16'h7f40);
        op(8'ha5, 3'h3, 1'b1);
        for (int i = 0; i < 64; i++) cread(15'h7f40 + 15'(i), i[7:0]);
        sfr(1'b1, `FPC_ADDR_CMD, 8'h01);
        v = rnd();
        bput(6'd0, v);
        bput(6'd5, ~v);
        op(8'ha5, 3'h3, 1'b1);
        cread(15'h7f40, v);
        cread(15'h7f45, ~v);
        cread(15'h7f41, 8'h01);
        sfr(1'b1, `FPC_ADDR_CMD, 8'h01);
        bput(6'd5, 8'h00);
        op(8'ha5, 3'h2, 1'b1);
        cread(15'h7f45, 8'h00);
        cread(15'h7f40, v);
        for (int j = 0; j < 6; j++) op(j == 0 ? 8'h5a : j == 1 ? 8'h00 : 8'ha5, j < 2 ? 3'h3 : j == 2 ? 3'h0 : 3'(j + 2), 1'b1);
        cread(15'h7f45, 8'h00);
        pen_n <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            {psh, psl} <= s[1:0];
            prot((16'h1000 >> s) - 16'h0040, 1'b1);
            prot(16'h1000 >> s, 1'b0);
        end
        prot(16'h00c0, 1'b0);
        pen_n <= 1'b1;
        prot(16'h0100, 1'b0);
        check({7'h0, hlock}, 8'h00);
        op(8'ha5, 3'h4, 1'b1);
        check({7'h0, hlock}, 8'h01);
        conclude();
    end
endmodule // flash_program_controller_tb
`default_nettype wire
